// [rtl/dmc_cmd_handler.sv]
// direct-mode command handler: customer opcodes, position event, control commands
// assumes the host link delivers decoded commands and takes replies as pulses
`timescale 1ns/1ps
module dmc_cmd_handler
   import dmc_pkg::*;
#(
   parameter int AW = 10,
   parameter logic [31:0] VERSION_BIN = 32'h00000001,
   parameter logic [63:0] VERSION_STR = 64'h3030303056303030
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // command in
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdDirect,
   input wire logic [7:0] cmdOpcode,
   input wire logic [7:0] cmdType,
   input wire logic [7:0] cmdBank,
   input wire logic [31:0] cmdValue,
   output logic cmdOther,
   output logic cmdRejected,
   // reply out
   output logic replyValid,
   output logic [7:0] replyStatus,
   output logic [7:0] replyCommand,
   output logic [31:0] replyValue,
   output logic replySpecial,
   output logic [31:0] replyHigh,
   // motion events
   input wire logic moveIssued,
   input wire logic targetReached,
   // program executor
   output logic progRunning,
   output logic [AW-1:0] progCounter,
   input wire logic instrDone,
   input wire logic waitFlag,
   input wire logic execWr,
   input wire logic [1:0] execSel,
   input wire logic [31:0] execData,
   input wire logic [7:0] flagSet,
   output logic [7:0] progFlags,
   output logic factoryRestore,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata
);
   dmc_run_t runState, next_runState;
   logic downloadMode;
   logic [AW-1:0] dlPtr;
   logic [31:0] accu;
   logic [31:0] indexReg;
   logic [7:0] stackPtr;
   logic [31:0] userReply;
   logic eventOnce;
   logic eventEvery;
   logic [7:0] eventMask;
   logic eventArmed;
   logic eventDue;
   logic memRdPend;
   logic [7:0] memRdOp;
   logic [55:0] memRdData;

   // command decode
   wire take = cmdValid && cmdReady;
   wire isUser = (cmdOpcode >= OP_USER_FIRST) && (cmdOpcode <= OP_USER_LAST);
   wire isCtrl = (cmdOpcode >= OP_STOP) && (cmdOpcode <= OP_FACTORY);
   wire isEvent = cmdOpcode == OP_POS_EVENT;
   wire directOnly = isCtrl || isEvent;
   wire reject = take && directOnly && !cmdDirect; // RL3 RL9
   wire doCtrl = take && isCtrl && cmdDirect; // RL9
   wire doEvent = take && isEvent && cmdDirect; // RL3
   wire doStore = take && !directOnly && downloadMode; // RL15
   wire doUser = take && isUser && !downloadMode; // RL1
   wire doOther = take && !directOnly && !isUser && !downloadMode;
   wire opStop = doCtrl && cmdOpcode == OP_STOP;
   wire opRun = doCtrl && cmdOpcode == OP_RUN;
   wire opStep = doCtrl && cmdOpcode == OP_STEP;
   wire opReset = doCtrl && cmdOpcode == OP_RESET;
   wire opDlEnter = doCtrl && cmdOpcode == OP_DL_ENTER;
   wire opDlExit = doCtrl && cmdOpcode == OP_DL_EXIT;
   wire opMemRead = doCtrl && cmdOpcode == OP_MEM_READ;
   wire opStatus = doCtrl && cmdOpcode == OP_APP_STATUS;
   wire opVersion = doCtrl && cmdOpcode == OP_VERSION;
   wire opFactory = doCtrl && cmdOpcode == OP_FACTORY;
   wire factoryOk = opFactory && cmdValue == FACTORY_KEY; // RL20
   wire [AW-1:0] valueAddr = cmdValue[AW-1:0];

   // a memory read holds off the next command for its one-cycle latency
   assign cmdReady = !memRdPend;
   assign progRunning = runState != RUN_STOPPED;

   // mode code seen by the status query and the status register
   wire [7:0] modeCode = downloadMode ? MODE_DOWNLOAD :
                         (runState == RUN_RUNNING) ? MODE_RUNNING :
                         (runState == RUN_STEPPING) ? MODE_STEPPING : MODE_STOPPED;
   wire [15:0] dlPtrWide = 16'(dlPtr);
   wire [15:0] pcWide = 16'(progCounter);
   wire [7:0] waitByte = {7'h00, waitFlag};

   // status query answer by type
   wire [31:0] statusValue = (cmdType == TYPE_0) ? {modeCode, waitByte, dlPtrWide} : // RL18
                             (cmdType == TYPE_1) ? {modeCode, waitByte, pcWide} :
                             (cmdType == TYPE_2) ? accu :
                             (cmdType == TYPE_3) ? indexReg : 32'h00000000;

   // immediate reply value by opcode
   wire [31:0] eventValue = {24'h000000, cmdValue[7:0]}; // RL7
   wire [31:0] versionValue = (cmdType == TYPE_0) ? VERSION_STR[31:0] : VERSION_BIN; // RL19
   wire [31:0] immValue = doUser ? userReply : // RL1
                          doEvent ? eventValue :
                          opStatus ? statusValue :
                          opVersion ? versionValue : 32'h00000000;
   wire immSpecial = opVersion && cmdType == TYPE_0;
   wire [31:0] immHigh = immSpecial ? VERSION_STR[63:32] : 32'h00000000;

   // immediate reply for every accepted command but the factory command, memory reads and foreign opcodes outside download mode
   wire immReply = (doCtrl && !opFactory && !opMemRead) || doEvent || doUser || doStore; // RL20
   wire sendEvent = eventDue && !immReply && !memRdPend; // RL2

   // run state
   always_comb
   begin
      next_runState = runState;
      case (runState)
         RUN_STOPPED:
         begin
            if (opRun)
            begin
               next_runState = RUN_RUNNING; // RL12
            end
            else if (opStep)
            begin
               next_runState = RUN_STEPPING; // RL13
            end
         end
         RUN_RUNNING:
         begin
            if (opStop || opReset)
            begin
               next_runState = RUN_STOPPED; // RL11 RL14
            end
         end
         RUN_STEPPING:
         begin
            if (opStop || opReset || instrDone)
            begin
               next_runState = RUN_STOPPED; // RL13
            end
            else if (opRun)
            begin
               next_runState = RUN_RUNNING;
            end
         end
         default:
         begin
            next_runState = RUN_STOPPED;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         runState <= RUN_STOPPED;
      end
      else
      begin
         runState <= next_runState;
      end
   end

   // program counter: reset clears, run type 1 loads, executor advances
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         progCounter <= '0;
      end
      else if (opReset)
      begin
         progCounter <= '0; // RL14
      end
      else if (opRun && cmdType == TYPE_1)
      begin
         progCounter <= valueAddr; // RL12
      end
      else if (instrDone && progRunning)
      begin
         progCounter <= progCounter + 1'b1;
      end
   end

   // executor registers; a reset command overrides a same-cycle executor write
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         accu <= 32'h00000000;
         indexReg <= 32'h00000000;
         stackPtr <= 8'h00;
         progFlags <= 8'h00;
      end
      else if (opReset)
      begin
         accu <= 32'h00000000; // RL14
         indexReg <= 32'h00000000; // RL14
         stackPtr <= 8'h00; // RL14
         progFlags <= 8'h00; // RL14
      end
      else
      begin
         progFlags <= progFlags | flagSet;
         if (execWr && execSel == EXEC_ACCU)
         begin
            accu <= execData;
         end
         if (execWr && execSel == EXEC_INDEX)
         begin
            indexReg <= execData;
         end
         if (execWr && execSel == EXEC_SP)
         begin
            stackPtr <= execData[7:0];
         end
      end
   end

   // download mode and its write pointer
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         downloadMode <= 1'b0;
         dlPtr <= '0;
      end
      else if (opDlEnter)
      begin
         downloadMode <= 1'b1; // RL15
         dlPtr <= valueAddr; // RL15
      end
      else if (opDlExit)
      begin
         downloadMode <= 1'b0; // RL16
      end
      else if (doStore)
      begin
         dlPtr <= dlPtr + 1'b1;
      end
   end

   dmc_prog_mem #(
      .AW(AW),
      .DW(56)
   ) progMem (
      .mclk(mclk),
      .wrEn(doStore), // RL15
      .wrAddr(dlPtr),
      .wrData({cmdOpcode, cmdType, cmdBank, cmdValue}),
      .rdEn(opMemRead), // RL17
      .rdAddr(valueAddr),
      .rdData(memRdData)
   );

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         memRdPend <= 1'b0;
         memRdOp <= 8'h00;
      end
      else
      begin
         memRdPend <= opMemRead;
         memRdOp <= cmdOpcode;
      end
   end

   // position-reached request; one message per move, arrival wins over a late clear
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         eventOnce <= 1'b0;
         eventEvery <= 1'b0;
         eventMask <= 8'h00;
         eventArmed <= 1'b0;
         eventDue <= 1'b0;
      end
      else
      begin
         if (doEvent)
         begin
            eventOnce <= cmdType == TYPE_0; // RL5
            eventEvery <= cmdType == TYPE_1; // RL5
            eventMask <= cmdValue[7:0];
         end
         else if (moveIssued && eventOnce)
         begin
            eventOnce <= 1'b0; // RL21
         end
         if (moveIssued && (eventOnce || eventEvery))
         begin
            eventArmed <= 1'b1; // RL5
         end
         else if (targetReached)
         begin
            eventArmed <= 1'b0; // RL21
         end
         if (targetReached && eventArmed && !moveIssued)
         begin
            eventDue <= 1'b1; // RL2
         end
         else if (sendEvent)
         begin
            eventDue <= 1'b0; // RL21
         end
      end
   end

   // reply register: memory read, then immediate, then deferred arrival message
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         replyValid <= 1'b0;
         replyStatus <= 8'h00;
         replyCommand <= 8'h00;
         replyValue <= 32'h00000000;
         replySpecial <= 1'b0;
         replyHigh <= 32'h00000000;
      end
      else
      begin
         replyValid <= memRdPend || immReply || sendEvent;
         replySpecial <= memRdPend || immSpecial;
         if (memRdPend)
         begin
            replyStatus <= ST_OK; // RL17
            replyCommand <= memRdOp;
            replyValue <= memRdData[31:0];
            replyHigh <= {memRdData[55:32], 8'h00};
         end
         else if (immReply)
         begin
            replyStatus <= ST_OK; // RL1 RL7
            replyCommand <= cmdOpcode; // RL7
            replyValue <= immValue;
            replyHigh <= immHigh;
         end
         else if (sendEvent)
         begin
            replyStatus <= ST_REACHED; // RL8
            replyCommand <= OP_POS_EVENT; // RL8
            replyValue <= {24'h000000, eventMask}; // RL8
            replyHigh <= 32'h00000000;
         end
      end
   end

   // single-cycle strobes
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         factoryRestore <= 1'b0;
         cmdOther <= 1'b0;
         cmdRejected <= 1'b0;
      end
      else
      begin
         factoryRestore <= factoryOk; // RL20
         cmdOther <= doOther;
         cmdRejected <= reject; // RL3 RL9
      end
   end

   // register port
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         userReply <= USER_REPLY_RESET;
      end
      else if (regWr && regAddr == REG_USER_REPLY)
      begin
         userReply <= regWdata; // RL1
      end
   end

   wire [31:0] statusWord = {downloadMode, waitFlag, 6'h00, modeCode, pcWide};
   wire [31:0] eventWord = {8'h00, stackPtr, eventMask, 4'h0, eventDue, eventArmed,
                            eventEvery, eventOnce};
   wire [31:0] rdMux = (regAddr == REG_STATUS) ? statusWord :
                       (regAddr == REG_ACCU) ? accu :
                       (regAddr == REG_INDEX) ? indexReg :
                       (regAddr == REG_USER_REPLY) ? userReply :
                       (regAddr == REG_EVENT) ? eventWord : 32'h00000000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         regRdata <= 32'h00000000;
      end
      else
      begin
         regRdata <= regRd ? rdMux : 32'h00000000;
      end
   end
endmodule

// [rtl/dmc_pkg.sv]
// constants, opcodes, reply codes and register map of the direct-mode command handler
// assumes one 200 MHz clock and a host link that hands over whole decoded commands
// Overview of operation
// RL1 - eight customer opcodes reply status 100, user value
// RL2 - event request sends immediate and later reply
// RL3 - event request accepted only from direct host
// RL4 - host puts motor mask 1 in value
// RL5 - type 0 next move only, 1 every move
// RL6 - host should prefer repeating type 1
// RL7 - immediate reply status 100, echo 8A, mask
// RL8 - arrival reply status 128, echo 138, mask
// RL9 - control commands accepted only from direct host
// RL10 - host keeps motor/bank zero on control commands
// RL11 - opcode 128 stops running program
// RL12 - 129 runs; type 1 loads start address
// RL13 - 130 executes one instruction then halts
// RL14 - 131 stops, clears counters, registers, flags
// RL15 - 132 enters download, stores commands from address
// RL16 - 133 leaves download, execute normally again
// RL17 - 134 returns addressed program memory word
// RL18 - 135 reports status selected by type
// RL19 - 136 reports version, string or binary
// RL20 - 137 with key 1234 restores, no reply
// RL21 - one arrival message per move; one-shot clears
package dmc_pkg;
   // opcodes
   localparam logic [7:0] OP_USER_FIRST = 8'h40;
   localparam logic [7:0] OP_USER_LAST = 8'h47;
   localparam logic [7:0] OP_STOP = 8'h80;
   localparam logic [7:0] OP_RUN = 8'h81;
   localparam logic [7:0] OP_STEP = 8'h82;
   localparam logic [7:0] OP_RESET = 8'h83;
   localparam logic [7:0] OP_DL_ENTER = 8'h84;
   localparam logic [7:0] OP_DL_EXIT = 8'h85;
   localparam logic [7:0] OP_MEM_READ = 8'h86;
   localparam logic [7:0] OP_APP_STATUS = 8'h87;
   localparam logic [7:0] OP_VERSION = 8'h88;
   localparam logic [7:0] OP_FACTORY = 8'h89;
   localparam logic [7:0] OP_POS_EVENT = 8'h8a;
   // reply status codes
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_REACHED = 8'h80;
   // value keys and type selectors
   localparam logic [31:0] FACTORY_KEY = 32'h000004d2;
   localparam logic [7:0] TYPE_0 = 8'h00;
   localparam logic [7:0] TYPE_1 = 8'h01;
   localparam logic [7:0] TYPE_2 = 8'h02;
   localparam logic [7:0] TYPE_3 = 8'h03;
   // application mode codes reported by status type 0 and 1
   localparam logic [7:0] MODE_STOPPED = 8'h00;
   localparam logic [7:0] MODE_RUNNING = 8'h01;
   localparam logic [7:0] MODE_STEPPING = 8'h02;
   localparam logic [7:0] MODE_DOWNLOAD = 8'h03;
   // register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_ACCU = 8'h04;
   localparam logic [7:0] REG_INDEX = 8'h08;
   localparam logic [7:0] REG_USER_REPLY = 8'h0c;
   localparam logic [7:0] REG_EVENT = 8'h10;
   localparam logic [31:0] USER_REPLY_RESET = 32'h00000000;
   // status register field positions
   localparam int STAT_DL_BIT = 31;
   localparam int STAT_WAIT_BIT = 30;
   localparam int STAT_MODE_LSB = 16;
   // executor write-port selectors
   localparam logic [1:0] EXEC_ACCU = 2'h0;
   localparam logic [1:0] EXEC_INDEX = 2'h1;
   localparam logic [1:0] EXEC_SP = 2'h2;
   typedef enum logic [2:0]
   {
      RUN_STOPPED = 3'b001,
      RUN_RUNNING = 3'b010,
      RUN_STEPPING = 3'b100
   } dmc_run_t;
endpackage

// [rtl/dmc_prog_mem.sv]
// program memory of the stored application, one write port, one read port
// assumes write and read come from the command handler in its own clock domain
`timescale 1ns/1ps
module dmc_prog_mem
   import dmc_pkg::*;
#(
   parameter int AW = 10,
   parameter int DW = 56
)
(
   // clock
   input wire logic mclk,
   // write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [DW-1:0] wrData,
   // read port, data one cycle after the request
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [DW-1:0] rdData
);
   // no reset on the array so it maps onto block memory
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge mclk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rdEn)
      begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// [tb/direct_mode_control_commands_bench.sv]
// bench for the command handler: host model, motion and executor stimulus
// assumes the checker binds itself to the handler
`timescale 1ns/1ps
module direct_mode_control_commands_bench
   import dmc_pkg::*;
;
   localparam logic [31:0] VB = 32'h0000a5c3; // arbitrary
   localparam logic [63:0] VS = 64'h3132333456353637; // arbitrary
   logic mclk = 1'b0, rst_n = 1'b0, reqGo = 1'b0, reqDir = 1'b0, regWr = 1'b0, regRd = 1'b0;
   logic moveIssued = 1'b0, targetReached = 1'b0, instrDone = 1'b0, waitFlag = 1'b0;
   logic execWr = 1'b0;
   logic [1:0] execSel = EXEC_ACCU;
   logic [7:0] reqOp = 8'h00, reqType = 8'h00, flagSet = 8'h00, regAddr = 8'h00;
   logic [31:0] reqValue = 32'h0, execData = 32'h0, regWdata = 32'h0;
   logic cmdValid, cmdReady, cmdDirect, cmdOther, cmdRejected, replyValid, replySpecial;
   logic progRunning, factoryRestore, rv, rj, ot, fr;
   logic [7:0] cmdOpcode, cmdType, cmdBank, replyStatus, replyCommand, progFlags;
   logic [31:0] cmdValue, replyValue, replyHigh, regRdata;
   logic [9:0] progCounter;
   int errors = 0, n_checks = 0, cycles = 0;
   always #2.5 mclk = ~mclk;
   dmc_host_model i_host (.*);
   dmc_cmd_handler #(.AW(10), .VERSION_BIN(VB), .VERSION_STR(VS)) i_dut (.*);
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // reply of a 134 lands one cycle later than the rest
   task automatic send(input logic [7:0] op, ty, input logic [31:0] v, input logic dir);
      @(posedge mclk);
      reqGo <= 1'b1;
      reqOp <= op;
      reqType <= ty;
      reqValue <= v;
      reqDir <= dir;
      @(posedge mclk);
      reqGo <= 1'b0;
      @(posedge mclk);
      if (op == OP_MEM_READ)
         @(posedge mclk);
      #1;
      rv = replyValid;
      rj = cmdRejected;
      ot = cmdOther;
      fr = factoryRestore;
   endtask
   task automatic rep(input logic [7:0] st, cm, input logic [31:0] v);
      chk({15'h0, rv, replyStatus, replyCommand, replyValue}, {15'h0, 1'b1, st, cm, v}, "reply");
   endtask
   task automatic move(input logic msg);
      @(posedge mclk);
      moveIssued <= 1'b1;
      @(posedge mclk);
      moveIssued <= 1'b0;
      repeat (3) @(posedge mclk);
      targetReached <= 1'b1;
      @(posedge mclk);
      targetReached <= 1'b0;
      // arrival flag sets at this edge, the message leaves one edge later
      @(posedge mclk);
      #1;
      chk({63'h0, replyValid}, {63'h0, msg}, "arrival");
      if (msg)
         chk({replyStatus, replyCommand, replyValue}, {ST_REACHED, OP_POS_EVENT, 32'h1}, "fields");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      chk({32'h0, regRdata}, {32'h0, e}, "register");
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= v;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         errors++;
         $display("mismatch at %0t: run too long", $time);
         wrap_up();
      end
   end
   initial
   begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(REG_STATUS, 32'h0);
      rd(REG_USER_REPLY, USER_REPLY_RESET);
      wr(REG_USER_REPLY, 32'hc0de0042);
      wr(8'h20, 32'hffffffff);
      rd(8'h20, 32'h0);
      $display("registers done");
      for (int i = 0; i < 8; i++)
      begin
         send(OP_USER_FIRST + 8'(i), 8'(i), 32'h0, 1'b1);
         rep(ST_OK, OP_USER_FIRST + 8'(i), 32'hc0de0042);
      end
      send(OP_POS_EVENT, TYPE_1, 32'h1, 1'b1);
      rep(ST_OK, OP_POS_EVENT, 32'h1);
      move(1'b1);
      move(1'b1);
      send(OP_POS_EVENT, TYPE_0, 32'h1, 1'b1);
      rep(ST_OK, OP_POS_EVENT, 32'h1);
      move(1'b1);
      move(1'b0);
      send(OP_POS_EVENT, TYPE_1, 32'h1, 1'b0);
      chk({62'h0, rj, rv}, 64'h2, "refused event");
      move(1'b0);
      send(OP_STOP, TYPE_0, 32'h0, 1'b0);
      chk({62'h0, rj, rv}, 64'h2, "refused control");
      $display("events done");
      send(OP_RUN, TYPE_1, 32'h5, 1'b1);
      rep(ST_OK, OP_RUN, 32'h0);
      rd(REG_STATUS, 32'h00010005);
      send(OP_STOP, TYPE_0, 32'h0, 1'b1);
      chk({63'h0, progRunning}, 64'h0, "stop");
      send(OP_STEP, TYPE_0, 32'h0, 1'b1);
      chk({63'h0, progRunning}, 64'h1, "step");
      @(posedge mclk);
      instrDone <= 1'b1;
      @(posedge mclk);
      instrDone <= 1'b0;
      #1;
      chk({53'h0, progRunning, progCounter}, {53'h0, 1'b0, 10'h6}, "step end");
      @(posedge mclk);
      execWr <= 1'b1;
      execData <= 32'h11;
      flagSet <= 8'h0f;
      @(posedge mclk);
      execSel <= EXEC_INDEX;
      execData <= 32'h22;
      flagSet <= 8'h00;
      @(posedge mclk);
      execWr <= 1'b0;
      send(OP_APP_STATUS, TYPE_2, 32'h0, 1'b1);
      rep(ST_OK, OP_APP_STATUS, 32'h11);
      send(OP_APP_STATUS, TYPE_3, 32'h0, 1'b1);
      rep(ST_OK, OP_APP_STATUS, 32'h22);
      send(OP_RESET, TYPE_0, 32'h0, 1'b1);
      chk({46'h0, progFlags, progCounter}, 64'h0, "reset clears");
      rd(REG_ACCU, 32'h0);
      rd(REG_INDEX, 32'h0);
      send(OP_VERSION, TYPE_1, 32'h0, 1'b1);
      rep(ST_OK, OP_VERSION, VB);
      send(OP_VERSION, TYPE_0, 32'h0, 1'b1);
      chk({replyHigh, replyValue}, VS, "version string");
      chk({62'h0, replySpecial, rv}, 64'h3, "special");
      $display("program control done");
      send(OP_DL_ENTER, TYPE_0, 32'h3, 1'b1);
      rep(ST_OK, OP_DL_ENTER, 32'h0);
      send(8'h05, TYPE_2, 32'h55, 1'b1);
      rep(ST_OK, 8'h05, 32'h0);
      send(OP_DL_EXIT, TYPE_0, 32'h0, 1'b1);
      rep(ST_OK, OP_DL_EXIT, 32'h0);
      send(8'h05, TYPE_2, 32'h55, 1'b1);
      chk({62'h0, ot, rv}, 64'h2, "executed again");
      send(OP_MEM_READ, TYPE_0, 32'h3, 1'b1);
      chk({31'h0, rv, replyHigh}, {31'h0, 1'b1, 8'h05, TYPE_2, 16'h0}, "word");
      chk({31'h0, replySpecial, replyValue}, {31'h0, 1'b1, 32'h55}, "value");
      send(OP_FACTORY, TYPE_0, 32'h000004d2, 1'b1);
      chk({62'h0, fr, rv}, 64'h2, "restore");
      send(OP_FACTORY, TYPE_0, 32'h000004d3, 1'b1);
      chk({62'h0, fr, rv}, 64'h0, "bad key");
      $display("download and restore done");
      wrap_up();
   end
endmodule

// [tb/dmc_cmd_handler_sva.sv]
// checker on the command handler ports
// assumes one clock domain; bound to the handler at the foot of this file
`timescale 1ns/1ps
module dmc_cmd_handler_sva
   import dmc_pkg::*;
#(
   parameter int AW = 10,
   parameter logic [31:0] VERSION_BIN = 32'h00000001
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // command
   input wire logic cmdValid,
   input wire logic cmdReady,
   input wire logic cmdDirect,
   input wire logic [7:0] cmdOpcode,
   input wire logic [7:0] cmdType,
   input wire logic [31:0] cmdValue,
   input wire logic cmdRejected,
   // reply
   input wire logic replyValid,
   input wire logic [7:0] replyStatus,
   input wire logic [7:0] replyCommand,
   input wire logic [31:0] replyValue,
   input wire logic replySpecial,
   // executor
   input wire logic progRunning,
   input wire logic [AW-1:0] progCounter,
   input wire logic [7:0] flagSet,
   input wire logic [7:0] progFlags,
   input wire logic factoryRestore
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   wire logic dTake = cmdValid && cmdReady && cmdDirect;
   wire logic isCtl = cmdOpcode >= OP_STOP && cmdOpcode <= OP_POS_EVENT;
   wire logic isUser = cmdOpcode >= OP_USER_FIRST && cmdOpcode <= OP_USER_LAST;
   wire logic keyOk = dTake && cmdOpcode == OP_FACTORY && cmdValue == FACTORY_KEY;
   AST_USER: assert property (
      dTake && isUser |=> replyValid && replyStatus == ST_OK && replyCommand == $past(cmdOpcode))
      else $error("customer opcode reply wrong");
   // an arrival message may share the cycle, so only an ok reply is excluded
   AST_REJECT: assert property (
      cmdValid && cmdReady && !cmdDirect && isCtl
      |=> cmdRejected && !(replyValid && replyStatus == ST_OK))
      else $error("program-side control command not refused");
   AST_EVT_ACK: assert property (
      dTake && cmdOpcode == OP_POS_EVENT |=> replyValid && replyStatus == ST_OK
      && replyCommand == OP_POS_EVENT && replyValue == ($past(cmdValue) & 32'h000000ff))
      else $error("event request reply wrong");
   AST_ARRIVE: assert property (
      replyValid && replyStatus == ST_REACHED
      |-> replyCommand == OP_POS_EVENT && replyValue[31:8] == 24'h000000)
      else $error("arrival reply wrong");
   AST_STOP: assert property (
      dTake && cmdOpcode == OP_STOP |=> !progRunning)
      else $error("program still running after stop");
   AST_RUN: assert property (
      dTake && cmdOpcode == OP_RUN && cmdType == TYPE_1
      |=> progRunning && progCounter == AW'($past(cmdValue)))
      else $error("run from address wrong");
   AST_CLEAR: assert property (
      dTake && cmdOpcode == OP_RESET && flagSet == 8'h00
      |=> !progRunning && progCounter == '0 && progFlags == 8'h00)
      else $error("program reset incomplete");
   AST_MEM_READ: assert property (
      dTake && cmdOpcode == OP_MEM_READ |=> !cmdReady ##1 replyValid && replySpecial)
      else $error("memory read reply timing wrong");
   AST_VERSION: assert property (
      dTake && cmdOpcode == OP_VERSION && cmdType == TYPE_1
      |=> replyValid && !replySpecial && replyValue == VERSION_BIN)
      else $error("binary version wrong");
   AST_FACTORY: assert property (
      keyOk |=> factoryRestore && !(replyValid && replyCommand == OP_FACTORY))
      else $error("factory restore missing or replied");
   AST_FACT_KEY: assert property (
      factoryRestore |-> $past(keyOk))
      else $error("factory restore without keyed command");
endmodule
bind dmc_cmd_handler dmc_cmd_handler_sva #(.AW(AW), .VERSION_BIN(VERSION_BIN)) u_sva (.*);

// [tb/dmc_host_model.sv]
// host model: presents one command at a time to the handler
// assumes the bench raises reqGo for one cycle per command
`timescale 1ns/1ps
module dmc_host_model
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // request from the bench
   input wire logic reqGo,
   input wire logic reqDir,
   input wire logic [7:0] reqOp,
   input wire logic [7:0] reqType,
   input wire logic [31:0] reqValue,
   // command to the handler
   output logic cmdValid,
   input wire logic cmdReady,
   output logic cmdDirect,
   output logic [7:0] cmdOpcode,
   output logic [7:0] cmdType,
   output logic [7:0] cmdBank,
   output logic [31:0] cmdValue
);
   // held until taken; idle fields flip so a stale command never looks valid
   always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
         cmdValid <= 1'b0;
         cmdDirect <= 1'b0;
         cmdOpcode <= 8'h00;
         cmdType <= 8'h00;
         cmdValue <= 32'h0;
      end
      else if (!cmdValid || cmdReady)
      begin
         cmdValid <= reqGo;
         cmdDirect <= reqGo ? reqDir : ~cmdDirect;
         cmdOpcode <= reqGo ? reqOp : ~cmdOpcode;
         cmdType <= reqGo ? reqType : ~cmdType;
         cmdValue <= reqGo ? reqValue : ~cmdValue;
      end
   assign cmdBank = 8'h00;
endmodule
